// *** hw/ebw_pkg.sv ***
// Function
// [RULE1] mode 00: internal ready follows external ready, counter ignored
// [RULE2] mode 01: internal ready follows counter ready, external ignored
// [RULE3] mode 10: internal ready low when either ready is low
// [RULE4] mode 11: internal ready low only when both readies are low
// [RULE5] access stretches while internal ready high, completes when it is low
// [RULE6] wait counter loads wait count field (0..7) at each access start
// [RULE7] counter decrements each cycle to zero, then holds zero
// [RULE8] counter ready high while counter nonzero, low at zero
// [RULE9] after reset every strobe uses seven wait states
// [RULE10] new wait settings may lag up to three instruction fetches
// [RULE11] per-strobe wait settings, identical on primary and expansion interfaces
// [RULE12] bank-switch detection only for strobe zero and strobe one
// [RULE13] compare value n compares address bits 23 down to 24-n
// [RULE14] compare values 16 and above compare only sixteen top bits
// [RULE15] last-access upper bits register, cleared at reset
// [RULE16] mismatching primary read gets one idle cycle with strobe high
// [RULE17] matching read proceeds normally without idle cycle
// [RULE18] stored bits update on reads and writes; idle only on reads
// [RULE19] compare value zero disables idle cycle insertion
// [RULE20] new compare width may lag up to three instruction fetches
// [RULE21] counter mode with count zero completes in first cycle
// [RULE22] external ready held high until memory can finish, then low
package ebw_pkg;
  localparam int ADDR_W = 24;
  localparam int CNT_W = 3;
  localparam int MODE_W = 2;
  localparam int CMP_W = 5;
  localparam logic [CNT_W-1:0] WAIT_RESET = 3'h7;
  localparam logic [CMP_W-1:0] CMP_RESET = 5'h00;
  localparam logic [CMP_W-1:0] CMP_MAX = 5'h10;
  localparam int MAX_CMP_BITS = 16;
  localparam int SETTLE_FETCHES = 3;
  typedef enum logic [MODE_W-1:0] {
    EBW_MODE_EXT = 2'h0,
    EBW_MODE_CNT = 2'h1,
    EBW_MODE_OR = 2'h2,
    EBW_MODE_AND = 2'h3
  } ebw_mode_t;
endpackage : ebw_pkg

// *** hw/ebw_wait_if.sv ***
`timescale 1ns/1ns
interface ebw_wait_if;
  import ebw_pkg::*;
  logic start;
  logic [CNT_W-1:0] waitCount;
  ebw_mode_t mode;
  logic extReady_n;
  logic internalReady_n;
  logic counterReady_n;
  modport ctrl (output start, output waitCount, output mode, output extReady_n,
    input internalReady_n, input counterReady_n);
  modport gen (input start, input waitCount, input mode, input extReady_n,
    output internalReady_n, output counterReady_n);
endinterface : ebw_wait_if

// *** hw/ebw_wait_gen.sv ***
`timescale 1ns/1ns
module ebw_wait_gen
  import ebw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  ebw_wait_if.gen w
);
  logic [CNT_W-1:0] count;

  // counter loads at access start, then runs down to zero and holds
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (w.start) begin
      // the start cycle already counts as the first cycle of the countdown
      count <= (w.waitCount != '0) ? w.waitCount - 3'h1 : '0; // see [RULE6]
    end else if (count != '0) begin
      count <= count - 3'h1; // see [RULE7]
    end
  end

  // on the start cycle the loaded value is what counts, so zero waits finishes at once
  logic [CNT_W-1:0] effCount;
  assign effCount = w.start ? w.waitCount : count;
  assign w.counterReady_n = (effCount != '0); // see [RULE8] [RULE21]

  always_comb begin
    unique case (w.mode)
      EBW_MODE_EXT: w.internalReady_n = w.extReady_n; // see [RULE1]
      EBW_MODE_CNT: w.internalReady_n = w.counterReady_n; // see [RULE2]
      EBW_MODE_OR: w.internalReady_n = w.extReady_n & w.counterReady_n; // see [RULE3]
      EBW_MODE_AND: w.internalReady_n = w.extReady_n | w.counterReady_n; // see [RULE4]
    endcase
  end

  chk_counter_hold: assert property (@(posedge clk) disable iff (rst)
    (!w.start && count == '0) |=> (count == '0 || $past(w.start)))
    else $error("wait counter left zero without a start"); // see [RULE7]
  chk_counter_ready: assert property (@(posedge clk) disable iff (rst)
    !w.start |-> (w.counterReady_n == (count != '0)))
    else $error("counter ready does not match counter"); // see [RULE8]
  chk_ext_mode: assert property (@(posedge clk) disable iff (rst)
    w.mode == EBW_MODE_EXT |-> w.internalReady_n == w.extReady_n)
    else $error("external mode ready mismatch"); // see [RULE1]
  chk_cnt_mode: assert property (@(posedge clk) disable iff (rst)
    w.mode == EBW_MODE_CNT |-> w.internalReady_n == w.counterReady_n)
    else $error("counter mode ready mismatch"); // see [RULE2]
  chk_or_mode: assert property (@(posedge clk) disable iff (rst)
    (w.mode == EBW_MODE_OR && (!w.extReady_n || !w.counterReady_n)) |-> !w.internalReady_n)
    else $error("either-ready mode failed to complete"); // see [RULE3]
  chk_and_mode: assert property (@(posedge clk) disable iff (rst)
    (w.mode == EBW_MODE_AND && (w.extReady_n || w.counterReady_n)) |-> w.internalReady_n)
    else $error("both-ready mode completed early"); // see [RULE4]
  chk_count_down: assert property (@(posedge clk) disable iff (rst)
    (w.start && w.waitCount == 3'h3 && w.mode == EBW_MODE_CNT) ##1 (!w.start)[*3]
    |-> !w.internalReady_n)
    else $error("three-wait access not ready on fourth cycle"); // see [RULE6]
endmodule : ebw_wait_gen

// *** hw/ebw_bus_ctrl.sv ***
`timescale 1ns/1ns
module ebw_bus_ctrl
  import ebw_pkg::*;
#(
  parameter int NUM_STROBES = 2,
  parameter int FETCH_LAG = SETTLE_FETCHES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic accessReq,
  input wire logic accessWrite,
  input wire logic accessExpansion,
  input wire logic [$clog2(NUM_STROBES+1)-1:0] accessStrobe,
  input wire logic [ADDR_W-1:0] accessAddr,
  input wire logic instrFetch,
  input wire logic cfgWrite,
  input wire logic cfgExpansion,
  input wire logic [$clog2(NUM_STROBES+1)-1:0] cfgStrobe,
  input wire logic [CNT_W-1:0] cfgWaitCount,
  input wire logic [MODE_W-1:0] cfgWaitMode,
  input wire logic [CMP_W-1:0] cfgBankCompare,
  input wire logic extReady_n,
  output logic accessDone,
  output logic internal_ready_n,
  output logic counter_ready_n,
  output logic bankIdle,
  output logic bus_strobe_n,
  output logic [ADDR_W-1:0] busAddr,
  output logic [CMP_W-1:0] bank_compare_width
);
  // strobes 0..NUM_STROBES-1 are primary, index NUM_STROBES is the expansion strobe
  localparam int NS = NUM_STROBES + 1;
  localparam int SW = $clog2(NS);
  localparam int LAG_W = $clog2(FETCH_LAG + 2);
  localparam logic [LAG_W-1:0] LAG_FULL = LAG_W'(FETCH_LAG);

  typedef enum logic [1:0] {EBW_IDLE, EBW_SWITCH, EBW_ACCESS} ebw_state_t;
  ebw_state_t state;

  // pending settings wait out the fetch lag before they take hold
  logic [CNT_W-1:0] pendCount [NS];
  logic [MODE_W-1:0] pendMode [NS];
  logic [CNT_W-1:0] liveCount [NS];
  logic [MODE_W-1:0] liveMode [NS];
  logic [CMP_W-1:0] pendCmp;
  logic [LAG_W-1:0] lag;
  logic [SW-1:0] cfgIdx;
  assign cfgIdx = cfgExpansion ? SW'(NUM_STROBES) : SW'(cfgStrobe);

  generate
    for (genvar i = 0; i < NS; i++) begin : g_strobe
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          pendCount[i] <= WAIT_RESET; // see [RULE9]
          pendMode[i] <= EBW_MODE_CNT;
          liveCount[i] <= WAIT_RESET; // see [RULE9]
          liveMode[i] <= EBW_MODE_CNT;
        end else begin
          if (cfgWrite && cfgIdx == SW'(i)) begin
            pendCount[i] <= cfgWaitCount; // see [RULE11]
            pendMode[i] <= cfgWaitMode;
          end
          if (lag == LAG_W'(1) && instrFetch) begin
            liveCount[i] <= pendCount[i]; // see [RULE10]
            liveMode[i] <= pendMode[i];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pendCmp <= CMP_RESET;
      bank_compare_width <= CMP_RESET;
    end else begin
      if (cfgWrite && !cfgExpansion) begin
        pendCmp <= cfgBankCompare;
      end
      if (lag == LAG_W'(1) && instrFetch) begin
        bank_compare_width <= pendCmp; // see [RULE20]
      end
    end
  end

  // a new write restarts the lag; changes land after the third fetch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lag <= '0;
    end else if (cfgWrite) begin
      lag <= LAG_FULL; // see [RULE10] [RULE20]
    end else if (instrFetch && lag != '0) begin
      lag <= lag - LAG_W'(1);
    end
  end

  // bank mask: top min(n,16) address bits
  logic [ADDR_W-1:0] bankMask;
  always_comb begin
    bankMask = '0;
    for (int b = 0; b < MAX_CMP_BITS; b++) begin
      if (bank_compare_width > CMP_W'(b)) begin
        bankMask[ADDR_W-1-b] = 1'b1; // see [RULE13] [RULE14]
      end
    end
  end

  logic [ADDR_W-1:0] lastBank;
  logic primary;
  logic banked;
  logic mismatch;
  assign primary = !accessExpansion;
  assign banked = primary && (accessStrobe == SW'(0) || accessStrobe == SW'(1)); // see [RULE12]
  assign mismatch = (accessAddr & bankMask) != lastBank;

  logic [SW-1:0] curIdx;
  logic [SW-1:0] reqIdx;
  assign reqIdx = accessExpansion ? SW'(NUM_STROBES) : SW'(accessStrobe);

  ebw_wait_if w ();
  logic startWait;
  assign w.start = startWait;
  assign w.waitCount = liveCount[reqIdx];
  // on the accepting cycle curIdx still names the previous access
  logic [SW-1:0] modeIdx;
  assign modeIdx = (state == EBW_IDLE) ? reqIdx : curIdx;
  assign w.mode = ebw_mode_t'(liveMode[modeIdx]);
  assign w.extReady_n = extReady_n;
  assign internal_ready_n = w.internalReady_n;
  assign counter_ready_n = w.counterReady_n;

  ebw_wait_gen u_wait (
    .clk(clk),
    .rst(rst),
    .w(w)
  );

  logic needSwitch;
  // zero width gives an all-zero mask, but lastBank may still hold older bits, so width zero is gated here
  assign needSwitch = banked && !accessWrite && (bank_compare_width != '0) && mismatch; // see [RULE16] [RULE18] [RULE19]

  // counter starts when the strobe actually goes active
  always_comb begin
    startWait = 1'b0;
    if (state == EBW_IDLE && accessReq && !needSwitch) begin
      startWait = 1'b1; // see [RULE17]
    end else if (state == EBW_SWITCH) begin
      startWait = 1'b1;
    end
  end

  logic active;
  assign active = startWait || state == EBW_ACCESS;
  assign accessDone = active && !w.internalReady_n; // see [RULE5]
  assign bus_strobe_n = !active; // see [RULE16]
  // the inserted cycle is the accepting cycle itself: strobe held high
  assign bankIdle = (state == EBW_IDLE) && accessReq && needSwitch; // see [RULE16]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= EBW_IDLE;
      curIdx <= '0;
    end else begin
      unique case (state)
        EBW_IDLE: begin
          if (accessReq) begin
            curIdx <= reqIdx;
            if (needSwitch) begin
              state <= EBW_SWITCH; // see [RULE16]
            end else if (w.internalReady_n) begin
              state <= EBW_ACCESS; // see [RULE5]
            end
          end
        end
        EBW_SWITCH: state <= w.internalReady_n ? EBW_ACCESS : EBW_IDLE;
        EBW_ACCESS: if (!w.internalReady_n) state <= EBW_IDLE; // see [RULE5]
        default: state <= EBW_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busAddr <= '0;
    end else if (state == EBW_IDLE && accessReq) begin
      busAddr <= accessAddr;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lastBank <= '0; // see [RULE15]
    end else if (state == EBW_IDLE && accessReq && primary) begin
      lastBank <= accessAddr & bankMask; // see [RULE18]
    end
  end

  chk_switch_idle: assert property (@(posedge clk) disable iff (rst)
    (state == EBW_IDLE && accessReq && needSwitch) |-> (bus_strobe_n && bankIdle) ##1 !bus_strobe_n)
    else $error("bank switch did not insert one idle cycle"); // see [RULE16]
  chk_no_write_idle: assert property (@(posedge clk) disable iff (rst)
    (state == EBW_IDLE && accessReq && accessWrite) |-> !bus_strobe_n)
    else $error("write was delayed by bank switch"); // see [RULE18]
  chk_cmp_zero: assert property (@(posedge clk) disable iff (rst)
    (bank_compare_width == '0) |-> !needSwitch)
    else $error("idle cycle with compare width zero"); // see [RULE19]
  chk_stretch: assert property (@(posedge clk) disable iff (rst)
    (active && internal_ready_n) |=> (state == EBW_ACCESS))
    else $error("access not stretched while not ready"); // see [RULE5]
  chk_last_reset: assert property (@(posedge clk)
    $fell(rst) |-> lastBank == '0)
    else $error("last bank not cleared by reset"); // see [RULE15]
endmodule : ebw_bus_ctrl

// *** testbench/ebw_mem_model.sv ***
`timescale 1ns/1ns
module ebw_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic strobe_n,
  input wire logic [3:0] latency,
  output logic extReady_n
);
  logic [3:0] lowCount;
  // counts strobe-low cycles already seen; saturates so a long access stays ready
  always_ff @(posedge clk or posedge rst) begin
    if (rst || strobe_n) begin
      lowCount <= 4'h0;
    end else if (lowCount != 4'hf) begin
      lowCount <= lowCount + 4'h1;
    end
  end
  // not ready until latency cycles elapsed, then ready until strobe lifts
  assign extReady_n = !(!strobe_n && lowCount >= latency);
endmodule : ebw_mem_model

// *** testbench/tb.sv ***
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
  import ebw_pkg::*;
  logic clk = 0, rst = 1, accessReq = 0, accessWrite = 0, accessExpansion = 0;
  logic instrFetch = 0, cfgWrite = 0, cfgExpansion = 0, extReady_n;
  logic [1:0] accessStrobe = 0, cfgStrobe = 0, cfgWaitMode = 0;
  logic [ADDR_W-1:0] accessAddr = 0, busAddr;
  logic [CNT_W-1:0] cfgWaitCount = 0;
  logic [CMP_W-1:0] cfgBankCompare = 0, bank_compare_width;
  logic accessDone, internal_ready_n, counter_ready_n, bankIdle, bus_strobe_n;
  logic [3:0] latency = 0;
  int mismatches = 0, n_checks = 0, lat, m, t;
  always #5 clk = ~clk;
  ebw_bus_ctrl i_ebw_bus_ctrl (.clk, .rst, .accessReq, .accessWrite, .accessExpansion,
    .accessStrobe, .accessAddr, .instrFetch, .cfgWrite, .cfgExpansion, .cfgStrobe,
    .cfgWaitCount, .cfgWaitMode, .cfgBankCompare, .extReady_n, .accessDone,
    .internal_ready_n, .counter_ready_n, .bankIdle, .bus_strobe_n, .busAddr,
    .bank_compare_width);
  ebw_mem_model i_ebw_mem_model (.clk, .rst, .strobe_n(bus_strobe_n), .latency, .extReady_n);
  function automatic logic mf(logic [1:0] md, logic x, logic c);
    case (md)
      2'h0: return x;
      2'h1: return c;
      2'h2: return x & c;
      default: return x | c;
    endcase
  endfunction : mf
  function automatic int xl(int md, int l, int w);
    case (md)
      0: return l + 1;
      1: return w + 1;
      2: return (l < w ? l : w) + 1;
      default: return (l > w ? l : w) + 1;
    endcase
  endfunction : xl
  task automatic cfg(input logic [1:0] s, input logic e, input int w, input logic [1:0] md,
      input int c);
    cfgStrobe = s;
    cfgExpansion = e;
    cfgWaitCount = w[2:0];
    cfgWaitMode = md;
    cfgBankCompare = c[4:0];
    cfgWrite = 1;
    @(negedge clk);
    cfgWrite = 0;
    // new settings only guaranteed after the fetch lag
    repeat (SETTLE_FETCHES) begin
      instrFetch = 1;
      @(negedge clk);
      instrFetch = 0;
      @(negedge clk);
    end
    if (!e && c <= 16) `CHK(bank_compare_width, c[4:0])
  endtask : cfg
  task automatic acc(input logic [1:0] s, input logic e, input logic wr,
      input logic [23:0] a, input logic [1:0] md, input int l, input int xLow, input int xIdle);
    int nLow, nIdle, k;
    nLow = 0;
    nIdle = 0;
    latency = l[3:0];
    accessStrobe = s;
    accessExpansion = e;
    accessWrite = wr;
    accessAddr = a;
    accessReq = 1;
    // sample each cycle after inputs settle, the accepting cycle included
    for (k = 0; k < 40; k++) begin
      #1;
      if (bankIdle === 1'b1) begin
        nIdle++;
        `CHK(bus_strobe_n, 1'b1)
      end else if (bus_strobe_n === 1'b0) begin
        nLow++;
        `CHK(internal_ready_n, mf(md, extReady_n, counter_ready_n))
        `CHK(accessDone, ~internal_ready_n)
        if (accessDone === 1'b1) break;
      end
      @(negedge clk);
    end
    // request stays up through the completing edge
    @(negedge clk);
    accessReq = 0;
    `CHK(nLow, xLow)
    `CHK(nIdle, xIdle)
    `CHK(busAddr, a)
    @(negedge clk);
  endtask : acc
  task test_done;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  // generous: the whole sequence needs well under a thousand cycles
  initial begin
    #200000;
    mismatches++;
    test_done();
  end
  initial begin
    repeat (5) @(negedge clk);
    `CHK(bus_strobe_n, 1'b1)
    `CHK(bank_compare_width, 5'h00)
    rst = 0;
    @(negedge clk);
    acc(0, 0, 0, 24'h0, 1, 0, 8, 0);
    acc(1, 0, 1, 24'h0, 1, 0, 8, 0);
    acc(0, 1, 0, 24'h0, 1, 0, 8, 0);
    $display("test reset defaults done");
    for (t = 0; t < 8; t++) begin
      cfg(1, 0, t, 1, 0);
      acc(1, 0, t[0], 24'h0, 1, 9, t + 1, 0);
    end
    $display("test wait counts done");
    for (t = 0; t < 3; t++) begin
      for (m = 0; m < 4; m++) begin
        cfg(t[1:0], t == 2, 3, m[1:0], 0);
        for (lat = 1; lat <= 5; lat += 4) begin
          acc(t[1:0], t == 2, 0, 24'h0, m[1:0], lat, xl(m, lat, 3), 0);
        end
      end
    end
    $display("test wait modes done");
    cfg(0, 0, 2, 1, 0);
    cfg(1, 0, 5, 1, 0);
    acc(0, 0, 0, 24'h0, 1, 0, 3, 0);
    acc(1, 0, 0, 24'h0, 1, 0, 6, 0);
    $display("test per strobe done");
    cfg(0, 0, 0, 1, 8);
    cfg(1, 0, 0, 1, 8);
    cfg(2, 1, 0, 1, 8);
    acc(0, 0, 0, 24'h120000, 1, 0, 1, 1);
    acc(0, 0, 0, 24'h12ffff, 1, 0, 1, 0);
    acc(0, 0, 1, 24'h340000, 1, 0, 1, 0);
    acc(0, 0, 0, 24'h340001, 1, 0, 1, 0);
    acc(1, 0, 0, 24'h560000, 1, 0, 1, 1);
    acc(0, 1, 0, 24'h990000, 1, 0, 1, 0);
    acc(0, 0, 0, 24'h560000, 1, 0, 1, 0);
    cfg(0, 0, 0, 1, 20);
    acc(0, 0, 0, 24'h550000, 1, 0, 1, 1);
    acc(0, 0, 0, 24'h550010, 1, 0, 1, 0);
    cfg(0, 0, 0, 1, 16);
    acc(0, 0, 0, 24'h550100, 1, 0, 1, 1);
    cfg(0, 0, 0, 1, 1);
    acc(0, 0, 0, 24'h000000, 1, 0, 1, 1);
    acc(0, 0, 0, 24'h7fffff, 1, 0, 1, 0);
    cfg(0, 0, 0, 1, 0);
    acc(0, 0, 0, 24'hff0000, 1, 0, 1, 0);
    $display("test bank switching done");
    test_done();
  end
endmodule : tb
